// [dv/sadc_host_model.sv]
// Host clock source, analog stand-in and bus wire model for the converter
`timescale 1ns/1ps
module sadc_host_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] half,
  input  wire logic [7:0] target,
  input  wire logic [7:0] sar_code,
  input  wire logic [7:0] bus_o,
  input  wire logic [7:0] bus_oe_n,
  output logic            conv_clk,
  output logic            comp_keep,
  output logic            busy,
  output logic [3:0]      rises,
  output logic [7:0]      bus_wire
);
  logic [3:0] cnt_reg  = 4'h1;
  logic [7:0] last_reg = 8'h00;

  // Clock stands low and idle marker shows until a burst is asked for
  initial
  begin
    conv_clk = 1'b0;
    busy     = 1'b0;
    rises    = 4'hf;
  end

  // Burst of eight rises, each level held for half MCLK cycles
  always @(negedge clk)
  begin
    if (!busy)
    begin
      busy    <= go;
      rises   <= go ? 4'h0 : 4'hf;
      cnt_reg <= 4'h1;
    end
    else if (cnt_reg != half)
      cnt_reg <= cnt_reg + 4'h1;
    else
    begin
      cnt_reg <= 4'h1;
      if (!conv_clk && rises == 4'h8)
        busy <= 1'b0;
      else
      begin
        conv_clk <= !conv_clk;
        if (!conv_clk)
          rises <= rises + 4'h1;
      end
    end
  end

  // Comparator keeps a trial bit while the code does not pass the input
  assign comp_keep = (sar_code <= target);

  // Released lanes show the inverse of the last level seen with all eight lanes driven
  assign bus_wire = (bus_o & ~bus_oe_n) | (~last_reg & bus_oe_n);
  always @(posedge clk)
    last_reg <= (bus_oe_n === 8'h00) ? bus_o : last_reg;
endmodule // sadc_host_model

// [dv/test_sar_adc_bus_interface.sv]
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ps
module test_sar_adc_bus_interface;
  logic       mclk    = 1'b0;
  logic       sys_rst = 1'b1;
  logic       start_n = 1'b1;
  logic       cs_n    = 1'b1;
  logic       read_n  = 1'b1;
  logic       dsel    = 1'b1;
  logic       fsel    = 1'b1;
  logic       go      = 1'b0;
  logic       ce      = 1'b1;
  logic [3:0] half    = 4'h1;
  logic [7:0] tgt     = 8'h00;
  logic       conv_clk;
  logic       comp_keep;
  logic       busy;
  logic [3:0] rises;
  logic [7:0] wire_v;
  logic       done_n;
  logic [7:0] bus_o;
  logic [7:0] oe_n;
  logic [7:0] sar;
  int         failures    = 0;
  int         comparisons = 0;

  // Clock generation
  initial
  begin
    forever #50 mclk = ~mclk;
  end

  sadc_top dut (
    .MCLK(mclk), .SYS_RST(sys_rst), .CE(ce), .CONV_CLK(conv_clk),
    .START_N(start_n), .CS_N(cs_n), .READ_N(read_n), .DATA_OR_FLAG_SELECT(dsel),
    .FORMAT_SELECT(fsel), .COMP_KEEP(comp_keep), .CONVERSION_DONE_N(done_n),
    .RESULT_BUS_O(bus_o), .RESULT_BUS_OE_N(oe_n), .SAR_CODE(sar)
  );

  sadc_host_model host (
    .clk(mclk), .go(go), .half(half), .target(tgt), .sar_code(sar),
    .bus_o(bus_o), .bus_oe_n(oe_n), .conv_clk(conv_clk), .comp_keep(comp_keep),
    .busy(busy), .rises(rises), .bus_wire(wire_v)
  );

  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task test_done;
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for a rise count, 4'hf meaning the burst is over
  task wait_rises(input logic [3:0] n);
    int i;
    for (i = 0; i < 200 && rises !== n; i++)
    begin
      @(negedge mclk);
      #1;
    end
    chk({4'h0, rises}, {4'h0, n}, "clock burst stalled");
  endtask

  // One read cycle with chip select already low
  task rd(input logic ds, input logic fm, input logic [7:0] oe, input logic [7:0] val,
          input logic [7:0] mask);
    @(negedge mclk);
    read_n <= 1'b0;
    dsel   <= ds;
    fsel   <= fm;
    @(negedge mclk);
    chk(oe_n, oe, "lane enables");
    chk(wire_v & mask, val & mask, "bus value");
    read_n <= 1'b1;
  endtask

  // Full conversion against an input level, then every read kind
  task conv(input logic [7:0] t, input logic [3:0] h);
    @(negedge mclk);
    tgt     <= t;
    half    <= h;
    cs_n    <= 1'b0;
    start_n <= 1'b0;
    repeat (2) @(negedge mclk);
    chk({7'h00, done_n}, 8'h01, "flag not raised on clear");
    chk(sar, 8'h00, "register not cleared");
    start_n <= 1'b1;
    @(negedge mclk);
    go <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    wait_rises(4'h1);
    @(posedge mclk);
    #1;
    chk(sar, 8'h80, "first trial");
    rd(1'b0, 1'b1, 8'h7f, 8'h80, 8'h80);
    wait_rises(4'h8);
    chk({7'h00, done_n}, 8'h01, "flag fell early");
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h00, done_n}, 8'h00, "flag not low at end");
    chk(sar, t, "result code");
    rd(1'b1, 1'b1, 8'h00, t, 8'hff);
    rd(1'b1, 1'b0, 8'h00, t ^ 8'h80, 8'hff);
    rd(1'b0, 1'b0, 8'h7f, 8'h00, 8'h80);
    wait_rises(4'hf);
  endtask

  // Deselected start and read are ignored, read high floats the bus
  task desel(input logic [7:0] t);
    @(negedge mclk);
    cs_n    <= 1'b1;
    read_n  <= 1'b0;
    dsel    <= 1'b1;
    start_n <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(oe_n, 8'hff, "bus driven while deselected");
    chk({7'h00, done_n}, 8'h00, "start taken while deselected");
    chk(sar, t, "register changed while deselected");
    cs_n    <= 1'b0;
    read_n  <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(oe_n, 8'hff, "bus driven with read high");
    cs_n    <= 1'b1;
    start_n <= 1'b1;
    go      <= 1'b1;
    @(negedge mclk);
    go      <= 1'b0;
    wait_rises(4'h8);
    wait_rises(4'hf);
    chk(sar, 8'h00, "release taken while deselected");
    chk({7'h00, done_n}, 8'h01, "flag dropped while deselected");
    cs_n    <= 1'b0;
  endtask

  // Clock bursts while start is held low must not convert
  task hold;
    @(negedge mclk);
    start_n <= 1'b0;
    @(negedge mclk);
    go <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    wait_rises(4'h8);
    wait_rises(4'hf);
    chk(sar, 8'h00, "converted with start low");
    chk({7'h00, done_n}, 8'h01, "flag fell with start low");
    start_n <= 1'b1;
  endtask

  // Clock enable low freezes the block: a start is not taken
  task freeze(input logic [7:0] t);
    @(negedge mclk);
    ce      <= 1'b0;
    start_n <= 1'b0;
    repeat (3) @(negedge mclk);
    chk({7'h00, done_n}, 8'h00, "flag moved with enable low");
    chk(sar, t, "register moved with enable low");
    ce      <= 1'b1;
    start_n <= 1'b1;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(negedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({7'h00, done_n}, 8'h00, "flag reset value");
    chk(oe_n, 8'hff, "enables reset value");
    chk(sar, 8'h00, "register reset value");
    conv(8'h00, 4'h1);
    conv(8'hff, 4'h3);
    conv(8'ha5, 4'h1);
    desel(8'ha5);
    hold;
    conv(8'h5a, 4'h2);
    conv(8'h01, 4'h1);
    freeze(8'h01);
    test_done;
  end

  // Watchdog
  initial
  begin
    #2000000;
    failures++;
    test_done;
  end
endmodule // test_sar_adc_bus_interface

// [rtl/sadc_drive.sv]
// Bus drive decode: format, lane enables and status lane
`timescale 1ns/1ps
module sadc_drive (
  input  wire logic                       cs_n,
  input  wire logic                       rd_n,
  input  wire logic                       data_sel,
  input  wire logic                       fmt_sel,
  input  wire logic                       busy,
  input  wire logic [sadc_pkg::CODE_W-1:0] code,
  output logic [sadc_pkg::CODE_W-1:0]     bus_data,
  output logic [sadc_pkg::CODE_W-1:0]     bus_oe_n
);

  logic [sadc_pkg::CODE_W-1:0] fmt_code;

  // Two's complement flips the top bit of the offset code
  always_comb
  begin
    fmt_code = code;                                                // RULE12
    if (!fmt_sel)
      fmt_code[sadc_pkg::CODE_W-1] = ~code[sadc_pkg::CODE_W-1];     // RULE11
  end

  // Lane enables and data selection
  always_comb
  begin
    bus_data = fmt_code;                                            // RULE1
    bus_oe_n = sadc_pkg::OE_OFF;
    if (!cs_n && !rd_n)                                             // RULE6 RULE7 RULE8
    begin
      if (data_sel)
        bus_oe_n = sadc_pkg::OE_ALL;                                // RULE9
      else
      begin
        bus_oe_n = sadc_pkg::OE_STATUS;                             // RULE10
        bus_data = {busy, fmt_code[sadc_pkg::CODE_W-2:0]};
      end
    end
  end

endmodule // sadc_drive

// [rtl/sadc_pkg.sv]
// Shared constants and types for the SAR converter control block
// Behaviour
// RULE1: Result bus bit 0 is least significant, bit 7 most significant.
// RULE2: Done flag high while converting, low once a valid result exists.
// RULE3: Done flag is always driven, never floated by select or read.
// RULE4: Start, select and conversion clock all low clears the approximation register.
// RULE5: Conversion waits until start has been released high.
// RULE6: Requests and reads are accepted only while chip select is low.
// RULE7: Chip select high floats the bus and ignores other control inputs.
// RULE8: Bus is driven only while read is low, floated otherwise.
// RULE9: Data/flag select high during read drives all eight result bits.
// RULE10: Select low during read drives bit 7 with status, floats 0 to 6.
// RULE11: Format select low gives a two's complement result.
// RULE12: Format select high gives straight (offset) binary.
// RULE13: Host keeps conversion clock at or below 5.0 MHz; slower is tolerated.
// RULE14: Approximation register holds an eight-bit code 0 to 255 for the converter.
// RULE15: After the clear request the done flag goes high.
// RULE16: Conversion takes seven full clocks after the first rise, then flag low.
// RULE17: Each conversion starts with the top trial bit set, then lower bits.
// RULE18: Comparator keeps or clears each trial bit; final code is the result.
package sadc_pkg;

  localparam int unsigned CODE_W    = 8;                     // Width of the result code
  localparam int unsigned IDX_W     = 3;                     // Width of the trial bit index
  localparam logic [2:0]  MSB_IDX   = 3'h7;                  // Index of the first trial bit
  localparam logic [2:0]  LSB_IDX   = 3'h0;                  // Index of the last trial bit
  localparam logic [7:0]  CODE_RST  = 8'h00;                 // Cleared register value
  localparam logic [7:0]  MSB_TRIAL = 8'h80;                 // Register value at first trial
  localparam logic [7:0]  OE_OFF    = 8'hff;                 // All bus lanes released
  localparam logic [7:0]  OE_ALL    = 8'h00;                 // All bus lanes driven
  localparam logic [7:0]  OE_STATUS = 8'h7f;                 // Only the top lane driven
  localparam logic [7:0]  BUS_RST   = 8'h00;                 // Bus data value at reset
  localparam int unsigned CONV_RISES = 7;                    // Rises after the start rise

  // Conversion sequence, Gray coded along the usual path
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CLEAR   = 2'b01,
    ST_ARMED   = 2'b11,
    ST_CONVERT = 2'b10
  } sadc_state_e;

endpackage

// [rtl/sadc_sar.sv]
// Successive-approximation register with per-bit trial logic
`timescale 1ns/1ps
module sadc_sar (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       clear,
  input  wire logic                       load_msb,
  input  wire logic                       decide,
  input  wire logic                       comp_keep,
  output logic [sadc_pkg::CODE_W-1:0]     code,
  output logic [sadc_pkg::IDX_W-1:0]      idx
);

  logic [sadc_pkg::CODE_W-1:0] code_reg;
  logic [sadc_pkg::CODE_W-1:0] code_next;
  logic [sadc_pkg::IDX_W-1:0]  idx_reg;
  logic [sadc_pkg::IDX_W-1:0]  idx_next;

  // Per-bit next value: keep, decide or set as next trial
  for (genvar b = 0; b < sadc_pkg::CODE_W; b++)
  begin : g_bit
    always_comb
    begin
      if (clear)
        code_next[b] = sadc_pkg::CODE_RST[b];                       // RULE4
      else if (load_msb)
        code_next[b] = sadc_pkg::MSB_TRIAL[b];                      // RULE17
      else if (decide && int'(idx_reg) == b)
        code_next[b] = comp_keep;                                   // RULE18
      else if (decide && idx_reg != sadc_pkg::LSB_IDX
               && int'(idx_reg - 3'h1) == b)
        code_next[b] = 1'b1;                                        // RULE17
      else
        code_next[b] = code_reg[b];
    end
  end

  // Trial index walks from top bit down
  always_comb
  begin
    if (clear || load_msb)
      idx_next = sadc_pkg::MSB_IDX;
    else if (decide && idx_reg != sadc_pkg::LSB_IDX)
      idx_next = idx_reg - 3'h1;
    else
      idx_next = idx_reg;
  end

  // Register stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code_reg <= sadc_pkg::CODE_RST;
      idx_reg  <= sadc_pkg::MSB_IDX;
    end
    else if (ce)
    begin
      code_reg <= code_next;
      idx_reg  <= idx_next;
    end
  end

  assign code = code_reg;  // RULE14
  assign idx  = idx_reg;

endmodule // sadc_sar

// [rtl/sadc_top.sv]
// Digital control of an eight-bit SAR converter on a processor bus
`timescale 1ns/1ps
module sadc_top (
  input  wire logic                       MCLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       CE,
  input  wire logic                       CONV_CLK,
  input  wire logic                       START_N,
  input  wire logic                       CS_N,
  input  wire logic                       READ_N,
  input  wire logic                       DATA_OR_FLAG_SELECT,
  input  wire logic                       FORMAT_SELECT,
  input  wire logic                       COMP_KEEP,
  output logic                            CONVERSION_DONE_N,
  output logic [7:0]                      RESULT_BUS_O,
  output logic [7:0]                      RESULT_BUS_OE_N,
  output logic [7:0]                      SAR_CODE
);

  sadc_pkg::sadc_state_e       state_reg;
  sadc_pkg::sadc_state_e       state_next;
  logic                        clk_prev_reg;
  logic                        clk_prev_next;
  logic                        done_n_reg;
  logic                        done_n_next;
  logic [7:0]                  bus_o_reg;
  logic [7:0]                  bus_oe_n_reg;
  logic [7:0]                  bus_data;
  logic [7:0]                  bus_oe_n;
  logic                        clk_rise;
  logic                        clk_fall;
  logic                        start_req;
  logic                        start_rel;
  logic                        sar_clear;
  logic                        sar_load;
  logic                        sar_decide;
  logic                        conv_last;
  logic [sadc_pkg::CODE_W-1:0] sar_code;
  logic [sadc_pkg::IDX_W-1:0]  sar_idx;

  // Conversion clock edges seen on the system clock
  assign clk_rise = CONV_CLK && !clk_prev_reg;
  assign clk_fall = !CONV_CLK && clk_prev_reg;

  // Request decode gated by chip select
  assign start_req = !START_N && !CS_N && !CONV_CLK;                // RULE4 RULE6
  assign start_rel = START_N && !CS_N;                              // RULE5 RULE7

  // Last decision is the rise after the lowest trial was set
  assign conv_last = (state_reg == sadc_pkg::ST_CONVERT) && clk_rise
                     && (sar_idx == sadc_pkg::LSB_IDX);             // RULE16

  // Approximation register steps
  assign sar_clear  = start_req;                                    // RULE4
  assign sar_load   = !start_req && (state_reg == sadc_pkg::ST_ARMED) && clk_rise;
  assign sar_decide = !start_req && (state_reg == sadc_pkg::ST_CONVERT)
                      && ((clk_fall && sar_idx != sadc_pkg::LSB_IDX) || conv_last);

  // Sequence next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sadc_pkg::ST_IDLE:
      begin
        if (start_req)
          state_next = sadc_pkg::ST_CLEAR;                          // RULE4
      end
      sadc_pkg::ST_CLEAR:
      begin
        if (start_rel)
          state_next = sadc_pkg::ST_ARMED;                          // RULE5
      end
      sadc_pkg::ST_ARMED:
      begin
        if (start_req)
          state_next = sadc_pkg::ST_CLEAR;
        else if (clk_rise)
          state_next = sadc_pkg::ST_CONVERT;                        // RULE16
      end
      sadc_pkg::ST_CONVERT:
      begin
        if (start_req)
          state_next = sadc_pkg::ST_CLEAR;
        else if (conv_last)
          state_next = sadc_pkg::ST_IDLE;                           // RULE16
      end
      default:
      begin
        state_next = sadc_pkg::ST_IDLE;
      end
    endcase
  end

  // Done flag and edge history next values
  always_comb
  begin
    clk_prev_next = CONV_CLK;
    done_n_next   = (state_next != sadc_pkg::ST_IDLE);              // RULE2 RULE15
  end

  // Sequence registers
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      state_reg    <= sadc_pkg::ST_IDLE;
      clk_prev_reg <= 1'b0;
      done_n_reg   <= 1'b0;
    end
    else if (CE)
    begin
      state_reg    <= state_next;
      clk_prev_reg <= clk_prev_next;
      done_n_reg   <= done_n_next;
    end
  end

  // Approximation register
  sadc_sar u_sar (
    .clk       (MCLK),
    .rst       (SYS_RST),
    .ce        (CE),
    .clear     (sar_clear),
    .load_msb  (sar_load),
    .decide    (sar_decide),
    .comp_keep (COMP_KEEP),
    .code      (sar_code),
    .idx       (sar_idx)
  );

  // Bus drive decode
  sadc_drive u_drive (
    .cs_n     (CS_N),
    .rd_n     (READ_N),
    .data_sel (DATA_OR_FLAG_SELECT),
    .fmt_sel  (FORMAT_SELECT),
    .busy     (done_n_reg),
    .code     (sar_code),
    .bus_data (bus_data),
    .bus_oe_n (bus_oe_n)
  );

  // Bus output registers
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      bus_o_reg    <= sadc_pkg::BUS_RST;
      bus_oe_n_reg <= sadc_pkg::OE_OFF;
    end
    else if (CE)
    begin
      bus_o_reg    <= bus_data;
      bus_oe_n_reg <= bus_oe_n;                                     // RULE8
    end
  end

  assign CONVERSION_DONE_N = done_n_reg;                            // RULE3
  assign RESULT_BUS_O      = bus_o_reg;
  assign RESULT_BUS_OE_N   = bus_oe_n_reg;
  assign SAR_CODE          = sar_code;                              // RULE14

  // Helper: conversion clock rises counted since the start rise
  logic [3:0] rise_cnt_reg;
  logic [3:0] rise_cnt_next;

  // Helper count next value
  always_comb
  begin
    rise_cnt_next = rise_cnt_reg;
    if (sar_load)
      rise_cnt_next = 4'h0;
    else if (clk_rise && state_reg == sadc_pkg::ST_CONVERT)
      rise_cnt_next = rise_cnt_reg + 4'h1;
  end

  // Helper count register
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      rise_cnt_reg <= 4'h0;
    else if (CE)
      rise_cnt_reg <= rise_cnt_next;
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  // Flag follows the busy sequence
  flag_busy_a: assert property (                                    // RULE2
    CE && state_reg == sadc_pkg::ST_CONVERT && !conv_last |=> CONVERSION_DONE_N
  ) else $error("Done flag low during conversion");

  // Clear request empties the register and raises the flag
  start_clear_a: assert property (                                  // RULE4
    CE && start_req |=> SAR_CODE == sadc_pkg::CODE_RST && CONVERSION_DONE_N
  ) else $error("Start request did not clear register");

  // No progress while start is held low
  start_hold_a: assert property (                                   // RULE5
    CE && state_reg == sadc_pkg::ST_CLEAR && !START_N
    |=> state_reg == sadc_pkg::ST_CLEAR
  ) else $error("Conversion left clear state while start low");

  // First rise loads the top trial bit
  msb_trial_a: assert property (                                    // RULE17
    CE && sar_load |=> SAR_CODE == sadc_pkg::MSB_TRIAL
  ) else $error("First trial is not the top bit");

  // Deselect floats every lane
  cs_float_a: assert property (                                     // RULE7
    CE && CS_N |=> RESULT_BUS_OE_N == sadc_pkg::OE_OFF
  ) else $error("Bus driven while deselected");

  // Read high floats every lane
  rd_float_a: assert property (                                     // RULE8
    CE && READ_N |=> RESULT_BUS_OE_N == sadc_pkg::OE_OFF
  ) else $error("Bus driven while read high");

  // Status read drives only the top lane with the flag
  status_read_a: assert property (                                  // RULE10
    CE && !CS_N && !READ_N && !DATA_OR_FLAG_SELECT
    |=> RESULT_BUS_OE_N == sadc_pkg::OE_STATUS
        && RESULT_BUS_O[7] == $past(CONVERSION_DONE_N)
  ) else $error("Status read lanes wrong");

  // Data read in two's complement flips the top bit
  data_read_a: assert property (                                    // RULE9
    CE && !CS_N && !READ_N && DATA_OR_FLAG_SELECT
    |=> RESULT_BUS_OE_N == sadc_pkg::OE_ALL
        && RESULT_BUS_O == ($past(FORMAT_SELECT) ? $past(SAR_CODE)
                            : ($past(SAR_CODE) ^ sadc_pkg::MSB_TRIAL))
  ) else $error("Data read value wrong");

  // Conversion ends on the seventh rise after the start rise
  conv_len_a: assert property (                                     // RULE16
    CE && conv_last |-> rise_cnt_reg == 4'(sadc_pkg::CONV_RISES - 1)
  ) else $error("Conversion length is not seven clocks");

  // Flag falls exactly when the last decision is taken
  flag_fall_a: assert property (                                    // RULE18
    CE && conv_last && !start_req |=> !CONVERSION_DONE_N
  ) else $error("Flag did not fall at end of conversion");

  // Deselected requests leave the idle sequence alone
  desel_idle_a: assert property (                                   // RULE6
    CE && CS_N && state_reg == sadc_pkg::ST_IDLE
    |=> state_reg == sadc_pkg::ST_IDLE
  ) else $error("Start taken while deselected");

  // Start release is not seen while deselected
  desel_clear_a: assert property (                                  // RULE7
    CE && CS_N && state_reg == sadc_pkg::ST_CLEAR
    |=> state_reg == sadc_pkg::ST_CLEAR
  ) else $error("Start release taken while deselected");

  // Register stays cleared until start is released
  clear_code_a: assert property (                                   // RULE5
    CE && state_reg == sadc_pkg::ST_CLEAR |=> SAR_CODE == sadc_pkg::CODE_RST
  ) else $error("Register moved before start release");

  // Armed sequence waits for the next conversion clock rise
  armed_wait_a: assert property (                                   // RULE16
    CE && state_reg == sadc_pkg::ST_ARMED && !clk_rise && !start_req
    |=> state_reg == sadc_pkg::ST_ARMED
  ) else $error("Conversion began without a clock rise");

  // Idle with no request keeps the flag low
  idle_flag_a: assert property (                                    // RULE2
    CE && state_reg == sadc_pkg::ST_IDLE && !start_req |=> !CONVERSION_DONE_N
  ) else $error("Done flag high while idle");

  // Register holds unless cleared, loaded or decided
  code_hold_a: assert property (                                    // RULE14
    CE && !sar_clear && !sar_load && !sar_decide |=> $stable(SAR_CODE)
  ) else $error("Register changed without a step");

  // Each decision stores the comparator answer in the trial bit
  keep_bit_a: assert property (                                     // RULE18
    CE && sar_decide |=> SAR_CODE[$past(sar_idx)] == $past(COMP_KEEP)
  ) else $error("Trial bit does not follow comparator");

  // Each decision above the last sets the next lower trial bit
  trial_walk_a: assert property (                                   // RULE17
    CE && sar_decide && sar_idx != sadc_pkg::LSB_IDX
    |=> sar_idx == $past(sar_idx) - 3'h1 && SAR_CODE[sar_idx]
  ) else $error("Next lower trial bit not set");

  // Straight binary read keeps the bottom and top lanes in their places
  lane_order_a: assert property (                                   // RULE1
    CE && !CS_N && !READ_N && DATA_OR_FLAG_SELECT && FORMAT_SELECT
    |=> RESULT_BUS_O[0] == $past(SAR_CODE[0])
        && RESULT_BUS_O[sadc_pkg::CODE_W-1] == $past(SAR_CODE[sadc_pkg::CODE_W-1])
  ) else $error("Result lanes out of order");

  // Two's complement read inverts only the top lane
  twos_read_a: assert property (                                    // RULE11
    CE && !CS_N && !READ_N && DATA_OR_FLAG_SELECT && !FORMAT_SELECT
    |=> RESULT_BUS_O[sadc_pkg::CODE_W-1] != $past(SAR_CODE[sadc_pkg::CODE_W-1])
        && RESULT_BUS_O[sadc_pkg::CODE_W-2:0] == $past(SAR_CODE[sadc_pkg::CODE_W-2:0])
  ) else $error("Two's complement read wrong");

  // Enable low freezes the sequence, flag and register
  ce_freeze_a: assert property (
    !CE |=> $stable(state_reg) && $stable(CONVERSION_DONE_N) && $stable(SAR_CODE)
  ) else $error("State moved with enable low");

endmodule // sadc_top
